// file: test/lde_field_model.sv
// lde_field_model: field side of the scan engine, switches on the input
// terminals and relay loads on the outputs.
// assumes the same clock as the engine and switch levels set by the bench.
`timescale 1ns/1ps
`default_nettype none

module lde_field_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic [11:0] sw_i,
  input wire logic [7:0] q_i,
  output logic [11:0] term_o,
  output logic [7:0] load_o
);
  logic [11:0] s1_q = 12'h000;
  logic [11:0] s2_q = 12'h000;
  logic [7:0] load_q = 8'h00;

  // a switch reaches its terminal after one cycle, or two when slow;
  // slow contacts show that late inputs are still picked up by a later pass
  always_ff @(posedge clk_i) begin
    s1_q <= sw_i;
    s2_q <= s1_q;
  end
  assign term_o = slow_i ? s2_q : s1_q;

  // relay loads pick up one cycle after the driver output
  always_ff @(posedge clk_i) begin
    load_q <= q_i;
  end
  assign load_o = load_q;
endmodule // lde_field_model
`default_nettype wire

// file: test/testbench.sv
// testbench: programs rungs over wishbone, runs the scan and judges relays.
// assumes lde_pkg and the engine with default parameters, 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import lde_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic slow = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] r;
  logic ack;
  logic [11:0] sw = 12'h000;
  logic [11:0] term;
  logic [7:0] q;
  logic [7:0] load;
  int err_total = 0;
  int checked = 0;
  int last = 127;

  initial forever #50 clk = ~clk;

  lde_scan_engine i_dut (.clk_sys_i(clk), .rst_i(rst), .in_i(term), .q_o(q),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  lde_field_model i_field (.clk_i(clk), .slow_i(slow), .sw_i(sw), .q_i(q),
    .term_o(term), .load_o(load));

  task automatic give_verdict;
    $display("mismatches %0d of %0d comparisons", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic cq(input logic [7:0] e);
    chk({24'h0, q}, {24'h0, e});
  endtask

  // one classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    r = rdat;
    if (n >= 20) begin
      err_total++;
      give_verdict();
    end
    cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'h0, a, 32'h0);
  endtask

  task automatic reset_dut;
    rst <= 1'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
  endtask

  // waits whole passes of 2*(last+1)+1 cycles, plus slack for the field side
  task automatic settle(input int n);
    repeat (n * (2 * last + 3) + 8) @(posedge clk);
  endtask

  function automatic logic [8:0] ct(input logic nc, input lde_op_e op, input logic [3:0] ix);
    return {1'h1, nc, op, ix};
  endfunction

  function automatic logic [9:0] cl(input lde_coil_fn_e f, input lde_coil_kind_e k,
                                    input logic [3:0] ix);
    return {1'h1, f, k, ix};
  endfunction

  task automatic put(input logic [6:0] a, input logic [37:0] w);
    wr(REG_ADDR, {25'h0, a});
    wr(REG_DATA_LO, w[31:0]);
    wr(REG_DATA_HI, {26'h0, w[37:32]});
    wr(REG_COMMIT, 32'h1);
  endtask

  // reset values including the image, unmapped offset
  task automatic t_reset;
    logic [7:0] a [6] = '{REG_CTRL, REG_STATUS, REG_PRESET, REG_LAST, REG_IMAGE, 8'h3C};
    logic [31:0] e [6] = '{32'h0, 32'h0, 32'h0A, 32'h7F, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rd(a[i]);
      chk(r, e[i]);
    end
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C);
    chk(r, 32'h0);
    cq(8'h00);
  endtask

  // seven rungs covering polarity, gaps, junctions and virtual outputs
  task automatic t_diagram;
    logic [37:0] w [7];
    logic [7:0] qe;
    logic q0;
    logic [31:0] s;
    last = 6;
    w[0] = {1'h0, cl(CF_CONTACTOR, CK_OUTPUT, 4'h0), 9'h000, ct(1'h1, OP_INPUT, 4'h1),
            ct(1'h0, OP_INPUT, 4'h0)};
    w[1] = {1'h0, cl(CF_CONTACTOR, CK_OUTPUT, 4'h1), 9'h000, ct(1'h1, OP_OTHER, 4'h0),
            ct(1'h1, OP_TSWITCH, 4'h0)};
    w[2] = {1'h0, cl(CF_CONTACTOR, CK_OUTPUT, 4'h9), 27'h0};
    w[3] = {1'h0, cl(CF_INVERT, CK_OUTPUT, 4'h3), 18'h0, ct(1'h0, OP_OUTPUT, 4'h0)};
    w[4] = {1'h0, cl(CF_CONTACTOR, CK_OUTPUT, 4'h4), ct(1'h0, OP_INPUT, 4'h0), 9'h000,
            ct(1'h0, OP_INPUT, 4'h0)};
    // three in series: in2, in2 and n/c of the idle in4, so the rung follows in2
    w[5] = {1'h0, cl(CF_CONTACTOR, CK_OUTPUT, 4'h5), ct(1'h1, OP_INPUT, 4'h4),
            ct(1'h0, OP_INPUT, 4'h2), ct(1'h0, OP_INPUT, 4'h2)};
    w[6] = {1'h1, cl(CF_CONTACTOR, CK_OUTPUT, 4'h6), 18'h0, ct(1'h0, OP_INPUT, 4'h3)};
    wr(REG_LAST, 32'h6);
    for (int i = 0; i < 7; i++) put(i[6:0], w[i]);
    rd(REG_STATUS);
    chk({31'h0, r[1]}, 32'h0);
    wr(REG_CTRL, 32'h1);
    for (int p = 0; p < 16; p++) begin
      sw <= {8'h00, p[3:0]};
      settle(2);
      q0 = p[0] & ~p[1];
      qe = {1'h0, p[3] | p[2], p[2], 1'h0, ~q0, 2'h0, q0};
      cq(qe);
      chk({24'h0, load}, {24'h0, qe});
      rd(REG_IMAGE);
      chk(r, {6'h00, 1'h1, 1'h0, qe, 16'h0000});
    end
    rd(REG_STATUS);
    s = r;
    settle(1);
    rd(REG_STATUS);
    chk({31'h0, r[0]}, 32'h1);
    chk({31'h0, r[15:8] != s[15:8]}, 32'h1);
    wr(REG_ADDR, 32'h4);
    rd(REG_FLOW);
    chk({31'h0, r[0]}, 32'h0);
    wr(REG_ADDR, 32'h2);
    rd(REG_FLOW);
    chk({31'h0, r[0]}, 32'h1);
    wr(REG_ADDR, 32'h1);
    rd(REG_FLOW);
    chk({31'h0, r[0]}, 32'h0);
    wr(REG_ADDR, 32'h5);
    rd(REG_FLOW);
    chk({31'h0, r[0]}, 32'h1);
    // a commit while running must leave the stored rung alone
    put(7'h00, {1'h0, cl(CF_CONTACTOR, CK_OUTPUT, 4'h7), 27'h0});
    sw <= 12'h001;
    settle(2);
    cq(8'h01);
    wr(REG_CTRL, 32'h0);
    settle(1);
    cq(8'h00);
    wr(REG_CTRL, 32'h1);
    settle(2);
    cq(8'h01);
  endtask

  // every coil function on a marker, one input rise then fall
  task automatic t_coil_fns;
    logic [7:0] e1 = 8'h15;
    logic [7:0] e0 = 8'h16;
    slow <= 1'h1;
    last = 0;
    for (int f = 0; f < 8; f++) begin
      sw <= 12'h000;
      reset_dut();
      wr(REG_LAST, 32'h0);
      put(7'h00, {1'h0, cl(lde_coil_fn_e'(f[2:0]), CK_MARKER, 4'h0), 18'h0,
                  ct(1'h0, OP_INPUT, 4'h0)});
      wr(REG_CTRL, 32'h1);
      settle(2);
      sw <= 12'h001;
      settle(3);
      rd(REG_IMAGE);
      chk({31'h0, r[0]}, {31'h0, e1[f]});
      sw <= 12'h000;
      settle(3);
      rd(REG_IMAGE);
      chk({31'h0, r[0]}, {31'h0, e0[f]});
    end
    slow <= 1'h0;
  endtask

  // on-delay timer and counter against a preset of three
  task automatic t_function;
    sw <= 12'h000;
    reset_dut();
    last = 3;
    wr(REG_PRESET, 32'h3);
    wr(REG_LAST, 32'h3);
    put(7'h00, {1'h0, cl(CF_CONTACTOR, CK_TIMER, 4'h0), 18'h0, ct(1'h0, OP_INPUT, 4'h0)});
    put(7'h01, {1'h0, cl(CF_CONTACTOR, CK_OUTPUT, 4'h0), 18'h0, ct(1'h0, OP_TIMER, 4'h0)});
    put(7'h02, {1'h0, cl(CF_CONTACTOR, CK_COUNTER, 4'h0), 18'h0, ct(1'h0, OP_INPUT, 4'h1)});
    put(7'h03, {1'h0, cl(CF_CONTACTOR, CK_OUTPUT, 4'h1), 18'h0, ct(1'h0, OP_COUNTER, 4'h0)});
    rd(REG_STATUS);
    chk({31'h0, r[1]}, 32'h1);
    wr(REG_CTRL, 32'h1);
    sw <= 12'h001;
    settle(1);
    cq(8'h00);
    settle(4);
    cq(8'h01);
    sw <= 12'h000;
    settle(2);
    cq(8'h00);
    for (int i = 0; i < 3; i++) begin
      sw <= 12'h002;
      settle(1);
      sw <= 12'h000;
      settle(1);
      cq({6'h00, i == 2, 1'h0});
    end
  endtask

  initial begin
    reset_dut();
    t_reset();
    t_diagram();
    t_coil_fns();
    t_function();
    give_verdict();
  end

  // hang guard: a stuck run counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule // testbench
`default_nettype wire

// file: verilog/lde_pkg.sv
// lde_pkg: constants, types and register map of the ladder scan engine.
// assumes a 32-bit classic wishbone slave port and one 10 MHz system clock.
package lde_pkg;

  // diagram geometry
  localparam int RUNG_MAX = 128;
  localparam int RIDX_W = 7;
  localparam int OPS = 16;
  localparam int IDX_W = 4;
  localparam int CT_FIELDS = 3;
  localparam int ADR_W = 8;
  localparam int CNT_W = 8;

  // reset values
  localparam logic [CNT_W-1:0] PRESET_RST = 8'h0A;
  localparam logic [RIDX_W-1:0] LAST_RST = 7'h7F;

  // register byte offsets, one 32-bit word each
  localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADR_W-1:0] REG_ADDR = 8'h08;
  localparam logic [ADR_W-1:0] REG_DATA_LO = 8'h0C;
  localparam logic [ADR_W-1:0] REG_DATA_HI = 8'h10;
  localparam logic [ADR_W-1:0] REG_COMMIT = 8'h14;
  localparam logic [ADR_W-1:0] REG_FLOW = 8'h18;
  localparam logic [ADR_W-1:0] REG_PRESET = 8'h1C;
  localparam logic [ADR_W-1:0] REG_LAST = 8'h20;
  localparam logic [ADR_W-1:0] REG_IMAGE = 8'h24;

  // contact operand sources
  typedef enum logic [2:0] {
    OP_INPUT = 3'h0,
    OP_MARKER = 3'h1,
    OP_OUTPUT = 3'h2,
    OP_TIMER = 3'h3,
    OP_COUNTER = 3'h4,
    OP_TSWITCH = 3'h5,
    OP_BUTTON = 3'h6,
    OP_OTHER = 3'h7
  } lde_op_e;

  // coil targets
  typedef enum logic [1:0] {
    CK_MARKER = 2'h0,
    CK_OUTPUT = 2'h1,
    CK_TIMER = 2'h2,
    CK_COUNTER = 2'h3
  } lde_coil_kind_e;

  // the seven coil functions; code 7 leaves the coil untouched
  typedef enum logic [2:0] {
    CF_CONTACTOR = 3'h0,
    CF_INVERT = 3'h1,
    CF_SET = 3'h2,
    CF_RESET = 3'h3,
    CF_TOGGLE = 3'h4,
    CF_RISE = 3'h5,
    CF_FALL = 3'h6,
    CF_NONE = 3'h7
  } lde_coil_fn_e;

  // scan sequencer
  typedef enum logic [1:0] {
    ST_STOP = 2'h0,
    ST_FETCH = 2'h1,
    ST_EVAL = 2'h2,
    ST_FUNC = 2'h3
  } lde_state_e;

  typedef struct packed {
    logic used;
    logic nc;
    lde_op_e op;
    logic [IDX_W-1:0] idx;
  } lde_contact_s;

  typedef struct packed {
    logic used;
    lde_coil_fn_e fn;
    lde_coil_kind_e kind;
    logic [IDX_W-1:0] idx;
  } lde_coil_s;

  // ct[0] is the leftmost contact field
  typedef struct packed {
    logic link_up;
    lde_coil_s coil;
    lde_contact_s [CT_FIELDS-1:0] ct;
  } lde_rung_s;

  localparam int RUNG_W = $bits(lde_rung_s);
  localparam int HI_W = RUNG_W - 32;

endpackage

// file: verilog/lde_rung_mem.sv
// lde_rung_mem: diagram store, one word per rung, registered read data.
// assumes one writer and one reader on the same clock.
`timescale 1ns/1ps
`default_nettype none

module lde_rung_mem #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] wa_i,
  input wire logic [WIDTH-1:0] wd_i,
  input wire logic [AW-1:0] ra_i,
  output logic [WIDTH-1:0] rd_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // no reset on purpose: the diagram survives a reset until rewritten
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[wa_i] <= wd_i; // R15
    end
  end

  // read data straight from a register
  always_ff @(posedge clk_i) begin
    rd_o <= mem_q[ra_i];
  end

endmodule // lde_rung_mem

`default_nettype wire

// file: verilog/lde_scan_engine.sv
// lde_scan_engine: cyclic ladder evaluator with a wishbone edit port.
// assumes classic wishbone, inputs synchronous to clk_sys_i, 10 MHz.
// Overview of operation
// R1 - run mode rescans the whole diagram continuously
// R2 - coil follows rung conduction and function
// R3 - timers and counters refreshed every pass
// R4 - closed contact gives 1, open gives 0
// R5 - each contact selectable normally open or closed
// R6 - seven coil functions selectable per coil
// R7 - unsupported contact types always read zero
// R8 - time switch contacts read zero without clock
// R9 - absent outputs act as internal markers
// R10 - three contacts, first fed from rail
// R11 - store holds up to 128 rungs
// R12 - links between rungs act as junctions
// R13 - conduction flows left to right only
// R14 - edit only in stop, run shows flow
// R15 - diagram kept until overwritten
// R16 - any contact type in any field
// R17 - relay contacts follow their coil state
// R18 - function element entry opens parameter view
// R19 - adjacent contacts chain in series, gaps break
// R20 - input terminals appear as input contacts
// R21 - series contacts AND, junctions OR
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module lde_scan_engine #(
  parameter int NUM_RUNGS = 128,
  parameter int NUM_I = 12,
  parameter int NUM_Q = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [NUM_I-1:0] in_i,
  output logic [NUM_Q-1:0] q_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lde_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import lde_pkg::*;

  localparam logic [RIDX_W-1:0] RIDX_END = RIDX_W'(NUM_RUNGS - 1);

  // refuse sizes the datapath cannot serve
  if (NUM_RUNGS < 1 || NUM_RUNGS > RUNG_MAX) begin : g_bad_rungs
    $error("NUM_RUNGS must be 1 to 128"); // R11
  end
  if (NUM_I < 1 || NUM_I > OPS || NUM_Q < 1 || NUM_Q > OPS) begin : g_bad_io
    $error("NUM_I and NUM_Q must be 1 to 16");
  end

  lde_state_e state_q;
  logic [RIDX_W-1:0] rung_q;
  logic acc_q;
  logic run_q;
  logic param_view_q;
  logic [RIDX_W-1:0] addr_q;
  logic [RIDX_W-1:0] last_q;
  logic [31:0] stage_lo_q;
  logic [HI_W-1:0] stage_hi_q;
  logic [CNT_W-1:0] preset_q;
  logic [CNT_W-1:0] pass_q;
  logic [OPS-1:0] m_q;
  logic [OPS-1:0] qs_q;
  logic [OPS-1:0] t_en_q;
  logic [OPS-1:0] c_in_q;
  logic [OPS-1:0] t_done;
  logic [OPS-1:0] c_done;
  logic [OPS-1:0] in_v;
  logic [RUNG_MAX-1:0] cond_q;
  logic [RUNG_W-1:0] rd_word;
  lde_rung_s rung_w;
  lde_rung_s stage_w;
  logic [CT_FIELDS-1:0] ct_st;
  logic pwr;
  logic gap;
  logic branch;
  logic coil_cur;
  logic coil_new;
  logic bus_req;
  logic bus_wr;
  logic mem_we;
  logic [31:0] rd_mux;

  // contact switching state; unsupported sources read zero either polarity
  function automatic logic op_state(input lde_contact_s c, input logic [OPS-1:0] iv,
                                    input logic [OPS-1:0] mv, input logic [OPS-1:0] qv,
                                    input logic [OPS-1:0] tv, input logic [OPS-1:0] cv);
    logic raw;
    logic ok;
    raw = 1'b0;
    ok = 1'b1;
    case (c.op) // R16
      OP_INPUT: raw = iv[c.idx]; // R20
      OP_MARKER: raw = mv[c.idx]; // R17
      OP_OUTPUT: raw = qv[c.idx]; // R9
      OP_TIMER: raw = tv[c.idx]; // R3
      OP_COUNTER: raw = cv[c.idx];
      OP_TSWITCH: ok = 1'b0; // R8
      default: ok = 1'b0; // R7
    endcase
    op_state = ok & (raw ^ c.nc); // R4 R5
  endfunction

  // the seven coil functions
  function automatic logic coil_next(input lde_coil_fn_e fn, input logic cur,
                                     input logic on, input logic was);
    case (fn) // R6
      CF_CONTACTOR: coil_next = on;
      CF_INVERT: coil_next = ~on;
      CF_SET: coil_next = cur | on;
      CF_RESET: coil_next = cur & ~on;
      CF_TOGGLE: coil_next = cur ^ (on & ~was);
      CF_RISE: coil_next = on & ~was;
      CF_FALL: coil_next = ~on & was;
      default: coil_next = cur;
    endcase
  endfunction

  // true when a word names a timer or counter, which carry parameters
  function automatic logic has_func_elem(input lde_rung_s w);
    logic f;
    f = w.coil.used & (w.coil.kind == CK_TIMER || w.coil.kind == CK_COUNTER);
    for (int k = 0; k < CT_FIELDS; k++) begin
      f = f | (w.ct[k].used & (w.ct[k].op == OP_TIMER || w.ct[k].op == OP_COUNTER));
    end
    has_func_elem = f;
  endfunction

  assign in_v = OPS'(in_i); // terminals above NUM_I read zero
  assign stage_w = lde_rung_s'({stage_hi_q, stage_lo_q});
  assign rung_w = lde_rung_s'(rd_word);

  lde_rung_mem #(
    .WIDTH(RUNG_W),
    .DEPTH(NUM_RUNGS),
    .AW(RIDX_W)
  ) u_mem (
    .clk_i(clk_sys_i),
    .we_i(mem_we),
    .wa_i(addr_q),
    .wd_i({stage_hi_q, stage_lo_q}),
    .ra_i(rung_q),
    .rd_o(rd_word)
  );

  // rung evaluation: rail feeds field 0, a gap between contacts breaks the path
  always_comb begin
    pwr = 1'b1; // R10
    gap = 1'b0;
    for (int k = 0; k < CT_FIELDS; k++) begin // R13
      ct_st[k] = op_state(rung_w.ct[k], in_v, m_q, qs_q, t_done, c_done);
      if (rung_w.ct[k].used) begin
        pwr = gap ? 1'b0 : (pwr & ct_st[k]); // R19 R21
      end else begin
        gap = 1'b1;
      end
    end
    branch = pwr | (rung_w.link_up & acc_q); // R12 R21
  end

  // current state of the coil's target, then its next state
  always_comb begin
    case (rung_w.coil.kind)
      CK_MARKER: coil_cur = m_q[rung_w.coil.idx];
      CK_OUTPUT: coil_cur = qs_q[rung_w.coil.idx];
      CK_TIMER: coil_cur = t_en_q[rung_w.coil.idx];
      default: coil_cur = c_in_q[rung_w.coil.idx];
    endcase
    coil_new = coil_next(rung_w.coil.fn, coil_cur, branch, cond_q[rung_q]); // R2
  end

  // scan sequencer: fetch, evaluate each rung, then refresh function relays
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= ST_STOP;
      rung_q <= '0;
      acc_q <= 1'b0;
    end else begin
      case (state_q)
        ST_STOP: begin
          rung_q <= '0;
          acc_q <= 1'b0;
          if (run_q) begin
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: state_q <= ST_EVAL;
        ST_EVAL: begin
          acc_q <= branch;
          if (rung_q == last_q || rung_q == RIDX_END) begin
            state_q <= ST_FUNC;
          end else begin
            rung_q <= rung_q + 7'h01;
            state_q <= ST_FETCH;
          end
        end
        ST_FUNC: begin
          rung_q <= '0;
          acc_q <= 1'b0;
          state_q <= run_q ? ST_FETCH : ST_STOP; // R1
        end
        default: state_q <= ST_STOP;
      endcase
    end
  end

  // power flow image, also the previous-pass state for edge coils
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cond_q <= '0;
    end else if (state_q == ST_EVAL) begin
      cond_q[rung_q] <= branch; // R14
    end
  end

  // coil targets update as each rung is evaluated
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      m_q <= '0;
      qs_q <= '0;
      t_en_q <= '0;
      c_in_q <= '0;
    end else if (state_q == ST_EVAL && rung_w.coil.used) begin
      case (rung_w.coil.kind)
        CK_MARKER: m_q[rung_w.coil.idx] <= coil_new; // R2
        CK_OUTPUT: qs_q[rung_w.coil.idx] <= coil_new; // R9
        CK_TIMER: t_en_q[rung_w.coil.idx] <= coil_new; // R3
        default: c_in_q[rung_w.coil.idx] <= coil_new;
      endcase
    end
  end

  // physical outputs refresh once per pass; stop drops them
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !run_q) begin
      q_o <= '0;
    end else if (state_q == ST_FUNC) begin
      q_o <= qs_q[NUM_Q-1:0]; // R9
    end
  end

  // on-delay timers counted in passes, edge counters; both clear in stop
  for (genvar i = 0; i < OPS; i++) begin : g_func
    logic [CNT_W-1:0] t_cnt_q;
    logic [CNT_W-1:0] c_cnt_q;
    logic c_prev_q;
    always_ff @(posedge clk_sys_i) begin
      if (rst_i || !run_q || !t_en_q[i]) begin
        t_cnt_q <= '0;
      end else if (state_q == ST_FUNC && t_cnt_q != preset_q) begin
        t_cnt_q <= t_cnt_q + 8'h01; // R3
      end
    end
    always_ff @(posedge clk_sys_i) begin
      if (rst_i || !run_q) begin
        c_cnt_q <= '0;
        c_prev_q <= 1'b0;
      end else if (state_q == ST_FUNC) begin
        c_prev_q <= c_in_q[i];
        if (c_in_q[i] && !c_prev_q && c_cnt_q != 8'hFF) begin
          c_cnt_q <= c_cnt_q + 8'h01; // R3
        end
      end
    end
    assign t_done[i] = t_en_q[i] && (t_cnt_q == preset_q);
    assign c_done[i] = (c_cnt_q >= preset_q);
  end

  // pass counter, visible in status so software sees the scan alive
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pass_q <= '0;
    end else if (state_q == ST_FUNC) begin
      pass_q <= pass_q + 8'h01; // R1
    end
  end

  // wishbone: one wait state, writes act on the edge that sees ack
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & wb_ack_o;
  // a pass still finishing after run clears keeps the store locked until stop
  assign mem_we = bus_wr && wb_adr_i == REG_COMMIT && wb_sel_i[0] && !run_q
                  && state_q == ST_STOP; // R14

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // control registers written by software
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
      addr_q <= '0;
      last_q <= LAST_RST;
      preset_q <= PRESET_RST;
      stage_lo_q <= '0;
      stage_hi_q <= '0;
    end else if (bus_wr) begin
      case (wb_adr_i)
        REG_CTRL: if (wb_sel_i[0]) run_q <= wb_dat_i[0];
        REG_ADDR: if (wb_sel_i[0]) addr_q <= wb_dat_i[RIDX_W-1:0];
        REG_LAST: if (wb_sel_i[0]) last_q <= wb_dat_i[RIDX_W-1:0];
        REG_PRESET: if (wb_sel_i[0]) preset_q <= wb_dat_i[CNT_W-1:0];
        REG_DATA_HI: if (wb_sel_i[0]) stage_hi_q <= wb_dat_i[HI_W-1:0];
        REG_DATA_LO: begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) stage_lo_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
        default: ;
      endcase
    end
  end

  // a committed function element sends the editor to its parameters
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      param_view_q <= 1'b0;
    end else if (mem_we) begin
      param_view_q <= has_func_elem(stage_w); // R18
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (wb_adr_i)
      REG_CTRL: rd_mux = {31'h0, run_q};
      REG_STATUS: rd_mux = {16'h0, pass_q, 6'h0, param_view_q, state_q != ST_STOP};
      REG_ADDR: rd_mux = {25'h0, addr_q};
      REG_DATA_LO: rd_mux = stage_lo_q;
      REG_DATA_HI: rd_mux = {{(32 - HI_W){1'b0}}, stage_hi_q};
      REG_FLOW: rd_mux = {31'h0, cond_q[addr_q]}; // R14
      REG_PRESET: rd_mux = {24'h0, preset_q};
      REG_LAST: rd_mux = {25'h0, last_q};
      REG_IMAGE: rd_mux = {qs_q, m_q};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req && !wb_ack_o) begin
      wb_dat_o <= rd_mux;
    end
  end

  // ---- checks ----
  logic [IDX_W-1:0] ck_idx_q;
  logic ck_val_q;
  logic ck_mk_q;
  always_ff @(posedge clk_sys_i) begin
    ck_idx_q <= rung_w.coil.idx;
    ck_val_q <= branch;
    ck_mk_q <= state_q == ST_EVAL && rung_w.coil.used && rung_w.coil.kind == CK_MARKER
               && rung_w.coil.fn == CF_CONTACTOR;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_PASS_LOOP: assert property ( // R1
    state_q == ST_FUNC && run_q |=> state_q == ST_FETCH && rung_q == 7'h00 ##1 state_q == ST_EVAL)
    else $error("scan did not restart after a pass");
  AST_CONTACTOR: assert property ( // R2
    ck_mk_q |-> m_q[ck_idx_q] == ck_val_q)
    else $error("contactor coil did not follow its rung");
  AST_NO_EDIT_RUN: assert property ( // R14
    mem_we |-> !run_q && state_q == ST_STOP)
    else $error("diagram written while running");
  AST_TSW_ZERO: assert property ( // R8
    state_q == ST_EVAL && rung_w.ct[0].used && rung_w.ct[0].op == OP_TSWITCH |-> !ct_st[0])
    else $error("time switch contact not zero");
  AST_UNSUP_ZERO: assert property ( // R7
    state_q == ST_EVAL && rung_w.ct[1].used && rung_w.ct[1].op == OP_OTHER |-> !ct_st[1])
    else $error("unsupported contact not zero");
  AST_NC_INPUT: assert property ( // R5
    state_q == ST_EVAL && rung_w.ct[0].used && rung_w.ct[0].op == OP_INPUT
    |-> ct_st[0] == (in_v[rung_w.ct[0].idx] ^ rung_w.ct[0].nc))
    else $error("input contact polarity wrong");
  AST_GAP_BREAKS: assert property ( // R19
    state_q == ST_EVAL && rung_w.ct[0].used && !rung_w.ct[1].used && rung_w.ct[2].used
    |-> !pwr)
    else $error("gap in rung did not break the path");
  AST_SERIES_AND: assert property ( // R21
    state_q == ST_EVAL && &{rung_w.ct[0].used, rung_w.ct[1].used, rung_w.ct[2].used}
    && !rung_w.link_up |-> branch == &ct_st)
    else $error("series contacts not combined as AND");
  AST_Q_REFRESH: assert property ( // R9
    state_q == ST_FUNC && run_q |=> q_o == $past(qs_q[NUM_Q-1:0]))
    else $error("outputs not refreshed at end of pass");
  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  COV_PASS: cover property (state_q == ST_FUNC ##1 state_q == ST_FETCH);
  COV_JUNCTION: cover property (state_q == ST_EVAL && rung_w.link_up && acc_q && !pwr);
  COV_EDIT: cover property (mem_we && has_func_elem(stage_w));
  COV_OUT_ON: cover property (q_o != '0);

endmodule // lde_scan_engine

`default_nettype wire
